// [rtl/remap_out_map.svh]
// Register offsets, field positions, reset values and sizes of the output map.
`ifndef REMAP_OUT_MAP_SVH
`define REMAP_OUT_MAP_SVH

// Byte offsets of the selector registers on the register bus.
`define REMAP_OUT_SELECT_PINS_0_1_OFS   12'h000
`define REMAP_OUT_SELECT_PINS_2_3_OFS   12'h004
`define REMAP_OUT_SELECT_PINS_4_5_OFS   12'h008
`define REMAP_OUT_SELECT_PINS_6_7_OFS   12'h00C
`define REMAP_OUT_SELECT_PINS_8_9_OFS   12'h010
`define REMAP_OUT_SELECT_PINS_10_11_OFS 12'h014
`define REMAP_OUT_SELECT_PINS_12_13_OFS 12'h018
`define REMAP_OUT_SELECT_PINS_14_15_OFS 12'h01C
`define REMAP_OUT_SELECT_PINS_16_17_OFS 12'h020
`define REMAP_OUT_SELECT_PINS_18_19_OFS 12'h024
`define REMAP_OUT_SELECT_PINS_20_21_OFS 12'h028
`define REMAP_OUT_SELECT_PINS_22_23_OFS 12'h02C

// Sizes of the block.
`define REMAP_OUT_NUM_REGS   12
`define REMAP_OUT_NUM_PINS   24
`define REMAP_OUT_NUM_FUNCS  64
`define REMAP_OUT_ADDR_W     12
`define REMAP_OUT_IDX_W      4

// Field layout of each selector register.
`define REMAP_OUT_FIELD_W    6
`define REMAP_OUT_EVEN_LSB   0
`define REMAP_OUT_ODD_LSB    8
`define REMAP_OUT_SEL_RESET  6'h00
`define REMAP_OUT_FUNC_NONE  6'h00

// Registers that the smaller variants leave out.
`define REMAP_OUT_IDX_PINS_8_9    4'h4
`define REMAP_OUT_IDX_PINS_10_11  4'h5
`define REMAP_OUT_IDX_PINS_16_17  4'h8
`define REMAP_OUT_IDX_PINS_18_19  4'h9

`endif

// [rtl/remap_out_pkg.sv]
// Types shared by the remappable output select block.
`include "remap_out_map.svh"
`default_nettype none

package remap_out_pkg;

    typedef logic [`REMAP_OUT_FIELD_W-1:0] sel_t;
    typedef logic [`REMAP_OUT_IDX_W-1:0]   reg_idx_t;

    // Device variants, smallest pin count first.
    typedef enum logic [1:0] {
        VARIANT_SMALL,
        VARIANT_MID,
        VARIANT_LARGE
    } variant_t;

    // APB request as driven by the master.
    typedef struct packed {
        logic                         psel;
        logic                         penable;
        logic                         pwrite;
        logic [`REMAP_OUT_ADDR_W-1:0] paddr;
        logic [31:0]                  pwdata;
        logic [3:0]                   pstrb;
    } apb_req_t;

    // APB answer from this slave.
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    // Whole state of the top module.
    typedef struct packed {
        sel_t [`REMAP_OUT_NUM_PINS-1:0] sel;
        apb_rsp_t                       rsp;
        logic [`REMAP_OUT_NUM_PINS-1:0] pin_data;
        logic [`REMAP_OUT_NUM_PINS-1:0] pin_routed;
    } state_t;

    // True when the variant carries the register at this index.
    function automatic logic reg_present(input variant_t v,
                                         input reg_idx_t idx);
        logic ok;
        ok = 1'b1;
        if ((idx == `REMAP_OUT_IDX_PINS_8_9) ||
            (idx == `REMAP_OUT_IDX_PINS_10_11)) begin
            ok = (v != VARIANT_SMALL);
        end
        if ((idx == `REMAP_OUT_IDX_PINS_16_17) ||
            (idx == `REMAP_OUT_IDX_PINS_18_19)) begin
            ok = (v == VARIANT_LARGE);
        end
        return ok;
    endfunction : reg_present

    // Builds the read word; unimplemented bits always read as zero.
    function automatic logic [31:0] pack_pair(input sel_t odd,
                                              input sel_t even);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`REMAP_OUT_ODD_LSB +: `REMAP_OUT_FIELD_W]  = odd;
        w[`REMAP_OUT_EVEN_LSB +: `REMAP_OUT_FIELD_W] = even;
        return w;
    endfunction : pack_pair

endpackage : remap_out_pkg

`default_nettype wire

// [rtl/remap_addr_decode.sv]
// Address decoder that maps a bus address onto a selector register index.
`include "remap_out_map.svh"
`default_nettype none

module remap_addr_decode #(
    parameter remap_out_pkg::variant_t VARIANT = remap_out_pkg::VARIANT_LARGE
) (
    input  wire logic [`REMAP_OUT_ADDR_W-1:0] paddr_i,
    output var  remap_out_pkg::reg_idx_t      idx_o,
    output var  logic                         mapped_o,
    output var  logic                         present_o
);
    import remap_out_pkg::*;

    localparam logic [`REMAP_OUT_ADDR_W-1:0]
        OFS [`REMAP_OUT_NUM_REGS] = '{
            `REMAP_OUT_SELECT_PINS_0_1_OFS,
            `REMAP_OUT_SELECT_PINS_2_3_OFS,
            `REMAP_OUT_SELECT_PINS_4_5_OFS,
            `REMAP_OUT_SELECT_PINS_6_7_OFS,
            `REMAP_OUT_SELECT_PINS_8_9_OFS,
            `REMAP_OUT_SELECT_PINS_10_11_OFS,
            `REMAP_OUT_SELECT_PINS_12_13_OFS,
            `REMAP_OUT_SELECT_PINS_14_15_OFS,
            `REMAP_OUT_SELECT_PINS_16_17_OFS,
            `REMAP_OUT_SELECT_PINS_18_19_OFS,
            `REMAP_OUT_SELECT_PINS_20_21_OFS,
            `REMAP_OUT_SELECT_PINS_22_23_OFS};

    // Full address compare, so aliases above the map never hit a register.
    always_comb begin
        idx_o    = '0;
        mapped_o = 1'b0;
        for (int i = 0; i < `REMAP_OUT_NUM_REGS; i++) begin
            if (paddr_i == OFS[i]) begin
                idx_o    = reg_idx_t'(i);
                mapped_o = 1'b1;
            end
        end
        present_o = mapped_o && reg_present(VARIANT, idx_o);
    end

endmodule : remap_addr_decode

`default_nettype wire

// [rtl/remap_pin_mux.sv]
// One pin's output selector: a peripheral function or the port latch.
`include "remap_out_map.svh"
`default_nettype none

module remap_pin_mux (
    input  wire remap_out_pkg::sel_t           sel_i,
    input  wire logic [`REMAP_OUT_NUM_FUNCS-1:0] periph_out_i,
    input  wire logic                          port_data_i,
    output var  logic                          pin_data_o,
    output var  logic                          pin_routed_o
);
    import remap_out_pkg::*;

    // Function zero is no peripheral, so the port keeps the pin.
    always_comb begin
        pin_routed_o = (sel_i != `REMAP_OUT_FUNC_NONE);
        pin_data_o   = pin_routed_o ? periph_out_i[sel_i] : port_data_i;
    end

endmodule : remap_pin_mux

`default_nettype wire

// [rtl/remappable_output_select.sv]
// Register bank and crossbar that steer peripheral outputs onto pins.
`include "remap_out_map.svh"
`default_nettype none

module remappable_output_select #(
    parameter remap_out_pkg::variant_t VARIANT = remap_out_pkg::VARIANT_LARGE
) (
    input  wire logic                            sys_clk_i,
    input  wire logic                            rst_b_i,
    input  wire logic                            ce_i,
    input  wire remap_out_pkg::apb_req_t         bus_req_i,
    output var  remap_out_pkg::apb_rsp_t         bus_rsp_o,
    input  wire logic [`REMAP_OUT_NUM_FUNCS-1:0] periph_out_i,
    input  wire logic [`REMAP_OUT_NUM_PINS-1:0]  port_data_i,
    output var  logic [`REMAP_OUT_NUM_PINS-1:0]  pin_data_o,
    output var  logic [`REMAP_OUT_NUM_PINS-1:0]  pin_routed_o
);
    import remap_out_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    ////////////////////////////////////////////////////////////////////////

    state_t                         s_r;
    state_t                         s_nxt;
    reg_idx_t                       dec_idx;
    logic                           dec_mapped;
    logic                           dec_present;
    logic                           access_ok;
    logic                           setup_phase;
    logic                           commit_write;
    logic [`REMAP_OUT_NUM_PINS-1:0] mux_data;
    logic [`REMAP_OUT_NUM_PINS-1:0] mux_routed;

    ////////////////////////////////////////////////////////////////////////
    // Address decode.
    ////////////////////////////////////////////////////////////////////////

    // The master holds the address through both phases, so one decoder
    // serves the setup answer and the write commit alike.
    remap_addr_decode #(
        .VARIANT   (VARIANT)
    ) u_decode (
        .paddr_i   (bus_req_i.paddr),
        .idx_o     (dec_idx),
        .mapped_o  (dec_mapped),
        .present_o (dec_present)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin crossbar.
    ////////////////////////////////////////////////////////////////////////

    // One selector per pin; pins whose register is absent keep a zero
    // selector forever and so stay under port control.
    for (genvar p = 0; p < `REMAP_OUT_NUM_PINS; p++) begin : g_pin
        remap_pin_mux u_mux (
            .sel_i        (s_r.sel[p]),
            .periph_out_i (periph_out_i),
            .port_data_i  (port_data_i[p]),
            .pin_data_o   (mux_data[p]),
            .pin_routed_o (mux_routed[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus phase qualifiers.
    ////////////////////////////////////////////////////////////////////////

    // A setup cycle is the first cycle of a selected transfer; the
    // registered pready keeps a held request from being answered twice.
    assign access_ok    = dec_mapped && dec_present;
    assign setup_phase  = bus_req_i.psel && !bus_req_i.penable &&
                          !s_r.rsp.pready;
    assign commit_write = bus_req_i.psel && bus_req_i.penable &&
                          s_r.rsp.pready && bus_req_i.pwrite && access_ok;

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    ////////////////////////////////////////////////////////////////////////

    // The answer is built in the setup cycle and shown for exactly the
    // one access cycle; absent and unmapped words answer with an error.
    always_comb begin
        s_nxt             = s_r;
        s_nxt.rsp.pready  = 1'b0;
        s_nxt.rsp.pslverr = 1'b0;
        s_nxt.rsp.prdata  = 32'h0000_0000;
        if (setup_phase) begin
            s_nxt.rsp.pready  = 1'b1;
            s_nxt.rsp.pslverr = !access_ok;
            if (!bus_req_i.pwrite && access_ok) begin
                for (int i = 0; i < `REMAP_OUT_NUM_REGS; i++) begin
                    if (dec_idx == reg_idx_t'(i)) begin
                        s_nxt.rsp.prdata = pack_pair(
                            s_r.sel[2*i+1], s_r.sel[2*i]);
                    end
                end
            end
        end
        // Byte lane 0 carries the even field, lane 1 the odd one; the
        // upper lanes and the unimplemented bits are simply dropped.
        if (commit_write) begin
            for (int i = 0; i < `REMAP_OUT_NUM_REGS; i++) begin
                if (dec_idx == reg_idx_t'(i)) begin
                    if (bus_req_i.pstrb[0]) begin
                        s_nxt.sel[2*i] = bus_req_i.pwdata[
                            `REMAP_OUT_EVEN_LSB +: `REMAP_OUT_FIELD_W];
                    end
                    if (bus_req_i.pstrb[1]) begin
                        s_nxt.sel[2*i+1] = bus_req_i.pwdata[
                            `REMAP_OUT_ODD_LSB +: `REMAP_OUT_FIELD_W];
                    end
                end
            end
        end
        // Pins are registered so they change one cycle after a selector
        // write; this keeps the crossbar off any pad timing path.
        s_nxt.pin_data   = mux_data;
        s_nxt.pin_routed = mux_routed;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    ////////////////////////////////////////////////////////////////////////

    // Reset clears every selector; a low clock enable freezes everything,
    // the bus handshake included, so a setup cycle that falls while it is low gets no answer.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    ////////////////////////////////////////////////////////////////////////

    // All outputs are flip-flop outputs taken straight from the state.
    assign bus_rsp_o    = s_r.rsp;
    assign pin_data_o   = s_r.pin_data;
    assign pin_routed_o = s_r.pin_routed;

endmodule : remappable_output_select

`default_nettype wire

// [test/remap_out_props.sv]
// Port-level checks for the remappable output select block.
`default_nettype none

module remap_out_props
    import remap_out_pkg::*;
#(
    parameter variant_t VARIANT = VARIANT_LARGE
) (
    input wire logic         sys_clk_i,
    input wire logic         rst_b_i,
    input wire logic         ce_i,
    input wire apb_req_t     bus_req_i,
    input wire apb_rsp_t     bus_rsp_o,
    input wire logic [63:0]  periph_out_i,
    input wire logic [23:0]  port_data_i,
    input wire logic [23:0]  pin_data_o,
    input wire logic [23:0]  pin_routed_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////////
    // A setup phase that the slave takes at this edge.
    sequence setup_s;
        bus_req_i.psel && !bus_req_i.penable && ce_i && !bus_rsp_o.pready;
    endsequence

    // The answer must come in the very next cycle, so no wait is allowed.
    a_ready_next: assert property (setup_s |=> bus_rsp_o.pready)
        else $error("ready missing after setup");
    a_ready_pulse: assert property (bus_rsp_o.pready && ce_i |=>
        !bus_rsp_o.pready) else $error("ready held too long");
    a_rsvd_zero: assert property (bus_rsp_o.pready |->
        (bus_rsp_o.prdata & 32'hFFFF_C0C0) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    a_err_nodata: assert property (bus_rsp_o.pslverr |->
        bus_rsp_o.prdata == 32'h0000_0000) else $error("data on error");
    a_low_ok: assert property (
        setup_s ##0 (bus_req_i.paddr <= 12'h00C &&
        bus_req_i.paddr[1:0] == 2'h0) |=> !bus_rsp_o.pslverr)
        else $error("present register refused");
    a_small_gap: assert property (
        setup_s ##0 (VARIANT == VARIANT_SMALL &&
        (bus_req_i.paddr == 12'h010 || bus_req_i.paddr == 12'h014))
        |=> bus_rsp_o.pslverr) else $error("absent pair 8..11 answered");
    a_large_only: assert property (
        setup_s ##0 (VARIANT != VARIANT_LARGE &&
        (bus_req_i.paddr == 12'h020 || bus_req_i.paddr == 12'h024))
        |=> bus_rsp_o.pslverr) else $error("absent pair 16..19 answered");
    // Unrouted pins must follow the port latch with one cycle of delay.
    a_port_idle: assert property ($past(ce_i) && $past(rst_b_i) |->
        (pin_data_o & ~pin_routed_o) == ($past(port_data_i) & ~pin_routed_o))
        else $error("idle pin not under port control");
    a_reset_clear: assert property ($rose(rst_b_i) |->
        pin_routed_o == 24'h00_0000) else $error("pin routed after reset");
endmodule : remap_out_props

bind remappable_output_select remap_out_props #(
    .VARIANT(VARIANT)
) remap_out_props_inst (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .bus_req_i   (bus_req_i),
    .bus_rsp_o   (bus_rsp_o),
    .periph_out_i(periph_out_i),
    .port_data_i (port_data_i),
    .pin_data_o  (pin_data_o),
    .pin_routed_o(pin_routed_o)
);

`default_nettype wire

// [test/tb_remappable_output_select.sv]
// Self-checking bench: three variants share one register bus.
`default_nettype none

module tb_remappable_output_select;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    sys_clk;
    logic                    rst_b;
    logic                    ce;
    remap_out_pkg::apb_req_t req;
    remap_out_pkg::apb_rsp_t rsp [3];
    logic [63:0]             periph;
    logic [23:0]             port_d;
    logic [23:0]             pin_d [3];
    logic [23:0]             pin_r [3];
    logic [31:0]             rd [3];
    logic                    er [3];
    int                      err_total;
    int                      n_checks;

    ////////////////////////////////////////////////////////////////////////
    // Index g is the variant: small, mid, large.
    for (genvar g = 0; g < 3; g++) begin : gen_var
        remappable_output_select #(
            .VARIANT(remap_out_pkg::variant_t'(g))
        ) remappable_output_select_inst (
            .sys_clk_i   (sys_clk),
            .rst_b_i     (rst_b),
            .ce_i        (ce),
            .bus_req_i   (req),
            .bus_rsp_o   (rsp[g]),
            .periph_out_i(periph),
            .port_data_i (port_d),
            .pin_data_o  (pin_d[g]),
            .pin_routed_o(pin_r[g])
        );
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One transfer; every variant answers, so all replies are captured.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        // The answer is taken at the very edge where pready is seen high.
        @(posedge sys_clk);
        while (rsp[2].pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                end_of_test();
            end
            @(posedge sys_clk);
        end
        for (int g = 0; g < 3; g++) begin
            rd[g] = rsp[g].prdata;
            er[g] = rsp[g].pslverr;
        end
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0000_0000);
            chk(rd[2], 32'h0000_0000);
        end
        $display("t_reset done");
    endtask : t_reset

    // Reserved bits are written as ones and must come back as zeros.
    task automatic t_fields;
        logic [31:0] e;
        for (int i = 0; i < 12; i++) begin
            e = 32'(((2 * i + 1) << 8) | (2 * i + 2));
            apb(1'b1, 12'(4 * i), 32'hFFFF_C0C0 | e);
        end
        for (int i = 0; i < 12; i++) begin
            e = 32'(((2 * i + 1) << 8) | (2 * i + 2));
            apb(1'b0, 12'(4 * i), 32'h0000_0000);
            chk(rd[2], e);
        end
        $display("t_fields done");
    endtask : t_fields

    // Odd pin p carries function p, even pin p carries function p+2.
    task automatic t_route;
        @(posedge sys_clk);
        periph <= 64'h0000_0000_01B4_E95A;
        port_d <= 24'hC3_A559;
        repeat (2) @(posedge sys_clk);
        #1;
        for (int p = 0; p < 24; p++) begin
            chk(32'(pin_d[2][p]), 32'(periph[p[0] ? p : p + 2]));
        end
        chk(32'(pin_r[2]), 32'h00FF_FFFF);
        chk(32'(pin_r[1]), 32'h00F0_FFFF);
        chk(32'(pin_r[0]), 32'h00F0_F0FF);
        chk(32'(pin_d[0][11:8]), 32'(port_d[11:8]));
        apb(1'b1, 12'h000, 32'h0000_0000);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(32'(pin_d[2][1:0]), 32'(port_d[1:0]));
        chk(32'(pin_r[2][1:0]), 32'h0000_0000);
        // A low clock enable must freeze the pins while the port moves.
        @(posedge sys_clk);
        ce     <= 1'b0;
        port_d <= 24'hC3_A55A;
        repeat (3) @(posedge sys_clk);
        chk(32'(pin_d[2][1:0]), 32'h0000_0001);
        ce <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(32'(pin_d[2][1:0]), 32'h0000_0002);
        $display("t_route done");
    endtask : t_route

    // Pairs 8..11 are absent on small; pairs 16..19 exist on large only.
    task automatic t_variants;
        logic [11:0] a;
        for (int k = 0; k < 4; k++) begin
            a = 12'h010 + 12'(k[1] * 16 + k[0] * 4);
            apb(1'b0, a, 32'h0000_0000);
            for (int g = 0; g < 3; g++) begin
                chk(32'(er[g]), 32'(k[1] ? g != 2 : g == 0));
            end
        end
        apb(1'b1, 12'h030, 32'h0000_0101);
        chk(32'(er[2]), 32'h0000_0001);
        apb(1'b0, 12'h002, 32'h0000_0000);
        chk(32'(er[2]), 32'h0000_0001);
        // Only lane 0 is strobed, so the odd field must keep its zero.
        req.pstrb <= 4'h1;
        apb(1'b1, 12'h000, 32'h0000_2A2A);
        req.pstrb <= 4'hF;
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd[2], 32'h0000_002A);
        $display("t_variants done");
    endtask : t_variants

    // A second reset in mid-run must clear selectors that hold values.
    task automatic t_rereset;
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd[2], 32'h0000_0000);
        chk(32'(pin_r[2]), 32'h0000_0000);
        $display("t_rereset done");
    endtask : t_rereset

    ////////////////////////////////////////////////////////////////////////
    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Reset, then the scenarios in turn.
    initial begin
        rst_b     = 1'b0;
        ce        = 1'b1;
        req       = '0;
        req.pstrb = 4'hF;
        periph    = 64'h0000_0000_0000_0000;
        port_d    = 24'h5A_3C96;
        err_total = 0;
        n_checks  = 0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_fields();
        t_route();
        t_variants();
        t_rereset();
        end_of_test();
    end
endmodule : tb_remappable_output_select

`default_nettype wire
